// ### hdl/ldio_decoder.sv
`timescale 1ns/1ps
`include "ldio_defs.svh"

module ldio_decoder #(
    parameter int NUM_WIN = 10
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic power_up_port_strap,
    input wire logic io_valid,
    input wire logic io_write,
    input wire logic [15:0] io_addr,
    input wire logic [7:0] io_wdata,
    output logic io_claim,
    output logic io_rvalid_ff,
    output logic [7:0] io_rdata_ff,
    output logic dev_strobe_ff,
    output logic dev_write_ff,
    output ldio_pkg::ldio_fn_t dev_fn_ff,
    output logic [10:0] dev_sel_ff,
    output logic [11:0] dev_offset_ff,
    output logic [7:0] dev_wdata_ff
);
    // Per-window limits, in enum order of the decoded targets.
    localparam logic [11:0] WIN_LO [NUM_WIN] = '{
        `LDIO_LO_STD, `LDIO_LO_STD, `LDIO_LO_STD, `LDIO_LO_STD, `LDIO_LO_STD,
        `LDIO_LO_STD, `LDIO_LO_STD, `LDIO_LO_PME, `LDIO_LO_STD, `LDIO_LO_CFG};
    localparam logic [11:0] WIN_HI [NUM_WIN] = '{
        `LDIO_HI_8B, `LDIO_HI_PP4, `LDIO_HI_8B, `LDIO_HI_8B, `LDIO_HI_8B,
        `LDIO_HI_8B, `LDIO_HI_GAME, `LDIO_HI_PME, `LDIO_HI_2B, `LDIO_HI_2B};
    localparam logic [11:0] WIN_AM [NUM_WIN] = '{
        `LDIO_AM_8B, `LDIO_AM_4B, `LDIO_AM_8B, `LDIO_AM_8B, `LDIO_AM_8B,
        `LDIO_AM_8B, `LDIO_AM_1B, `LDIO_AM_128B, `LDIO_AM_2B, `LDIO_AM_2B};
    localparam logic [7:0] WIN_SZ [NUM_WIN] = '{
        `LDIO_SZ_8B, `LDIO_SZ_8B, `LDIO_PP_EXT_SIZE, `LDIO_SZ_8B, `LDIO_SZ_8B,
        `LDIO_SZ_8B, `LDIO_SZ_1B, `LDIO_SZ_128B, `LDIO_SZ_2B, `LDIO_SZ_2B};
    localparam logic [3:0] WIN_LDN [NUM_WIN] = '{
        `LDIO_LDN_FDC, `LDIO_LDN_PP, `LDIO_LDN_PP, `LDIO_LDN_SP1, `LDIO_LDN_SP2,
        `LDIO_LDN_SP2, `LDIO_LDN_GAME, `LDIO_LDN_PME, `LDIO_LDN_MPU, 4'h0};
    localparam int W_PP = 1;
    localparam int W_PPX = 2;
    localparam int W_IR = 5;
    localparam int W_CFG = 9;
    localparam logic [11:0] RELOC_MASK = `LDIO_RELOC_LDN_MASK;

    logic strap_meta_ff;
    logic strap_sync_ff;
    logic [1:0] boot_cnt_ff;
    logic ready_ff;
    logic [7:0] index_ff;
    logic [7:0] ldn_ff;
    logic [7:0] global_osc_config_ff;
    logic [15:0] cfg_base_ff;
    logic [15:0] prim_base_ff [`LDIO_NUM_LDN];
    logic [15:0] sec_base_ff;
    logic qual16;
    logic pp8;
    logic [11:0] win_base [NUM_WIN];
    logic win_hit [NUM_WIN];
    logic [11:0] win_off [NUM_WIN];
    logic kbd_hit;
    logic any_hit;
    ldio_pkg::ldio_fn_t nxt_fn;
    logic [11:0] nxt_off;
    logic cfg_data_wr;
    logic cfg_data_rd;
    logic ldn_has_base;
    logic [7:0] cfg_rd_val;

    ldio_win_if win [NUM_WIN] ();

    assign qual16 = global_osc_config_ff[`LDIO_OSC_QUAL16_BIT];
    assign ldn_has_base = (ldn_ff < 8'(`LDIO_NUM_LDN))
        && RELOC_MASK[ldn_ff[3:0]];

    // The parallel port gains its upper registers only on an 8-byte boundary.
    // alignment modes
    assign pp8 = (prim_base_ff[`LDIO_LDN_PP][2:0] == 3'h0);

    // Pick each window's base register; most come from the primary pair.
    // primary base
    always_comb begin
        for (int i = 0; i < NUM_WIN; i++) begin
            win_base[i] = prim_base_ff[WIN_LDN[i]][11:0];
        end
        win_base[W_IR] = sec_base_ff[11:0];
        win_base[W_CFG] = cfg_base_ff[11:0];
    end

    // One comparator per window, all fed the same host address.
    genvar g;
    generate
        for (g = 0; g < NUM_WIN; g++) begin : g_win
            assign win[g].addr = io_addr;
            assign win[g].qual16 = qual16;
            assign win[g].base = win_base[g];
            assign win[g].lo = WIN_LO[g];
            assign win[g].hi = WIN_HI[g];
            assign win[g].amask = WIN_AM[g];
            assign win[g].en = (g == W_PPX) ? pp8 : 1'b1;
            assign win[g].add_off = (g == W_PPX) ? `LDIO_PP_EXT_OFF : 12'h000;
            assign win[g].size = (g == W_PP && !pp8) ? `LDIO_PP_SPP_SIZE : WIN_SZ[g];
            ldio_win_cmp u_cmp (
                .win(win[g])
            );
            assign win_hit[g] = win[g].hit;
            assign win_off[g] = win[g].off;
        end
    endgenerate

    // The keyboard unit answers at two fixed ports only.
    // fixed keyboard ports
    assign kbd_hit = (!qual16 || io_addr[15:12] == 4'h0)
        && (io_addr[11:0] == `LDIO_KBD_DATA_PORT || io_addr[11:0] == `LDIO_KBD_CMD_PORT);

    // Priority pick so that only one target is ever selected.
    // single select
    always_comb begin
        nxt_fn = ldio_pkg::ldio_fn_none;
        nxt_off = 12'h000;
        if (kbd_hit) begin
            nxt_fn = ldio_pkg::ldio_fn_keyboard_controller_unit;
            nxt_off = io_addr[11:0] - `LDIO_KBD_DATA_PORT;
        end
        for (int i = NUM_WIN - 1; i >= 0; i--) begin
            if (win_hit[i]) begin
                nxt_fn = ldio_pkg::ldio_fn_t'(4'(i));
                nxt_off = win_off[i];
            end
        end
        // The configuration port outranks every window, so the host can reach it at any even base.
        if (win_hit[W_CFG]) begin
            nxt_fn = ldio_pkg::ldio_fn_cfg;
            nxt_off = win_off[W_CFG];
        end
    end

    assign any_hit = ready_ff && (nxt_fn != ldio_pkg::ldio_fn_none);
    assign io_claim = io_valid && any_hit;

    // Index port at the base, data port one above it.
    // index and data ports
    assign cfg_data_wr = io_claim && io_write && nxt_fn == ldio_pkg::ldio_fn_cfg
        && nxt_off == `LDIO_CFG_DATA_OFF;
    assign cfg_data_rd = io_claim && !io_write && nxt_fn == ldio_pkg::ldio_fn_cfg;

    // Read value: the index itself at the index port, else the register that it points at.
    always_comb begin
        cfg_rd_val = 8'h00;
        if (nxt_off != `LDIO_CFG_DATA_OFF) begin
            cfg_rd_val = index_ff;
        end else begin
            unique case (index_ff)
                `LDIO_IDX_LDN: cfg_rd_val = ldn_ff;
                `LDIO_IDX_OSC: cfg_rd_val = global_osc_config_ff;
                `LDIO_IDX_CFG_HI: cfg_rd_val = cfg_base_ff[15:8];
                `LDIO_IDX_CFG_LO: cfg_rd_val = cfg_base_ff[7:0];
                `LDIO_IDX_PRIM_HI: cfg_rd_val = ldn_has_base ? prim_base_ff[ldn_ff[3:0]][15:8] : 8'h00;
                `LDIO_IDX_PRIM_LO: cfg_rd_val = ldn_has_base ? prim_base_ff[ldn_ff[3:0]][7:0] : 8'h00;
                `LDIO_IDX_SEC_HI: cfg_rd_val = (ldn_ff == 8'h05) ? sec_base_ff[15:8] : 8'h00;
                `LDIO_IDX_SEC_LO: cfg_rd_val = (ldn_ff == 8'h05) ? sec_base_ff[7:0] : 8'h00;
                default: cfg_rd_val = 8'h00;
            endcase
        end
    end

    // Two-flop synchroniser for the strap pin.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            strap_meta_ff <= 1'b0;
            strap_sync_ff <= 1'b0;
        end else begin
            strap_meta_ff <= power_up_port_strap;
            strap_sync_ff <= strap_meta_ff;
        end
    end

    // Hold off decoding until the synchronised strap has been sampled.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            boot_cnt_ff <= 2'h0;
            ready_ff <= 1'b0;
        end else if (!ready_ff) begin
            boot_cnt_ff <= boot_cnt_ff + 2'h1;
            ready_ff <= (boot_cnt_ff == `LDIO_STRAP_SETTLE);
        end
    end

    // Configuration port base: strap default, then software relocation.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg_base_ff <= `LDIO_CFG_BASE_STRAP0;
        end else if (!ready_ff && boot_cnt_ff == `LDIO_STRAP_SETTLE) begin
            cfg_base_ff <= strap_sync_ff ? `LDIO_CFG_BASE_STRAP1 : `LDIO_CFG_BASE_STRAP0;
        end else if (cfg_data_wr && index_ff == `LDIO_IDX_CFG_HI) begin
            cfg_base_ff[15:8] <= io_wdata;
        end else if (cfg_data_wr && index_ff == `LDIO_IDX_CFG_LO) begin
            cfg_base_ff[7:0] <= io_wdata;
        end
    end

    // Index, device number and global qualification registers.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            index_ff <= 8'h00;
            ldn_ff <= 8'h00;
            global_osc_config_ff <= `LDIO_OSC_RESET;
        end else if (io_claim && io_write && nxt_fn == ldio_pkg::ldio_fn_cfg) begin
            if (nxt_off != `LDIO_CFG_DATA_OFF) begin
                index_ff <= io_wdata;
            end else if (index_ff == `LDIO_IDX_LDN) begin
                ldn_ff <= io_wdata;
            end else if (index_ff == `LDIO_IDX_OSC) begin
                global_osc_config_ff <= io_wdata;
            end
        end
    end

    // Base pairs of the logical device selected by the device number.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `LDIO_NUM_LDN; i++) begin
                prim_base_ff[i] <= `LDIO_BASE_RESET;
            end
            sec_base_ff <= `LDIO_BASE_RESET;
        end else if (cfg_data_wr) begin
            if (ldn_has_base && index_ff == `LDIO_IDX_PRIM_HI) begin
                prim_base_ff[ldn_ff[3:0]][15:8] <= io_wdata;
            end
            if (ldn_has_base && index_ff == `LDIO_IDX_PRIM_LO) begin
                prim_base_ff[ldn_ff[3:0]][7:0] <= io_wdata;
            end
            if (ldn_ff == 8'h05 && index_ff == `LDIO_IDX_SEC_HI) begin
                sec_base_ff[15:8] <= io_wdata;
            end
            if (ldn_ff == 8'h05 && index_ff == `LDIO_IDX_SEC_LO) begin
                sec_base_ff[7:0] <= io_wdata;
            end
        end
    end

    // Configuration read data, one cycle after the request.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            io_rvalid_ff <= 1'b0;
            io_rdata_ff <= 8'h00;
        end else begin
            io_rvalid_ff <= cfg_data_rd;
            if (cfg_data_rd) begin
                io_rdata_ff <= cfg_rd_val;
            end
        end
    end

    // Registered routing of a function access with one-hot select.
    // routed select
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dev_strobe_ff <= 1'b0;
            dev_write_ff <= 1'b0;
            dev_fn_ff <= ldio_pkg::ldio_fn_none;
            dev_sel_ff <= 11'h000;
            dev_offset_ff <= 12'h000;
            dev_wdata_ff <= 8'h00;
        end else begin
            dev_strobe_ff <= io_claim && nxt_fn != ldio_pkg::ldio_fn_cfg;
            dev_sel_ff <= 11'h000;
            if (io_claim && nxt_fn != ldio_pkg::ldio_fn_cfg) begin
                dev_write_ff <= io_write;
                dev_fn_ff <= nxt_fn;
                dev_sel_ff <= 11'h001 << nxt_fn;
                dev_offset_ff <= nxt_off;
                dev_wdata_ff <= io_wdata;
            end
        end
    end
endmodule // ldio_decoder

// ### hdl/ldio_defs.svh
`ifndef LDIO_DEFS_SVH
`define LDIO_DEFS_SVH

// Configuration register indices reached through the data port.
`define LDIO_IDX_LDN 8'h07
`define LDIO_IDX_OSC 8'h24
`define LDIO_IDX_CFG_HI 8'h26
`define LDIO_IDX_CFG_LO 8'h27
`define LDIO_IDX_PRIM_HI 8'h60
`define LDIO_IDX_PRIM_LO 8'h61
`define LDIO_IDX_SEC_HI 8'h62
`define LDIO_IDX_SEC_LO 8'h63

// Field positions and reset values.
`define LDIO_OSC_QUAL16_BIT 6
`define LDIO_OSC_RESET 8'h00
`define LDIO_BASE_RESET 16'h0000
`define LDIO_CFG_BASE_STRAP0 16'h002e
`define LDIO_CFG_BASE_STRAP1 16'h004e
`define LDIO_STRAP_SETTLE 2'h2

// Logical device numbers and the set holding relocatable bases.
`define LDIO_NUM_LDN 12
`define LDIO_LDN_FDC 4'h0
`define LDIO_LDN_PP 4'h3
`define LDIO_LDN_SP1 4'h4
`define LDIO_LDN_SP2 4'h5
`define LDIO_LDN_GAME 4'h9
`define LDIO_LDN_PME 4'ha
`define LDIO_LDN_MPU 4'hb
`define LDIO_RELOC_LDN_MASK 12'he39

// Fixed ports and offsets.
`define LDIO_KBD_DATA_PORT 12'h060
`define LDIO_KBD_CMD_PORT 12'h064
`define LDIO_PP_EXT_OFF 12'h400
`define LDIO_PP_EXT_SIZE 8'h03
`define LDIO_PP_SPP_SIZE 8'h03
`define LDIO_CFG_DATA_OFF 12'h001

// Permitted base ranges, alignment masks and decoded spans.
`define LDIO_LO_STD 12'h100
`define LDIO_HI_8B 12'hff8
`define LDIO_HI_PP4 12'hffc
`define LDIO_HI_GAME 12'hfff
`define LDIO_LO_PME 12'h000
`define LDIO_HI_PME 12'hf7f
`define LDIO_HI_2B 12'hffe
`define LDIO_LO_CFG 12'h000
`define LDIO_AM_8B 12'h007
`define LDIO_AM_4B 12'h003
`define LDIO_AM_2B 12'h001
`define LDIO_AM_1B 12'h000
`define LDIO_AM_128B 12'h07f
`define LDIO_SZ_8B 8'h08
`define LDIO_SZ_2B 8'h02
`define LDIO_SZ_1B 8'h01
`define LDIO_SZ_128B 8'h80

`endif

// ### hdl/ldio_pkg.sv
package ldio_pkg;

    // Decoded target; the first ten values match the window order.
    typedef enum logic [3:0] {
        ldio_fn_fdc,
        ldio_fn_pp,
        ldio_fn_pp_ext,
        ldio_fn_sp1,
        ldio_fn_sp2,
        ldio_fn_infrared_engine_registers,
        ldio_fn_game,
        ldio_fn_pme,
        ldio_fn_mpu,
        ldio_fn_cfg,
        ldio_fn_keyboard_controller_unit,
        ldio_fn_none
    } ldio_fn_t;

endpackage

// ### hdl/ldio_win_if.sv
`timescale 1ns/1ps
// One address window: its base, limits and the compare result.
interface ldio_win_if;
    logic [15:0] addr;
    logic qual16;
    logic en;
    logic [11:0] base;
    logic [11:0] add_off;
    logic [11:0] lo;
    logic [11:0] hi;
    logic [11:0] amask;
    logic [7:0] size;
    logic hit;
    logic [11:0] off;

    modport cmp (
        input addr, qual16, en, base, add_off, lo, hi, amask, size,
        output hit, off
    );
    modport top (
        output addr, qual16, en, base, add_off, lo, hi, amask, size,
        input hit, off
    );
endinterface

// ### hdl/ldio_win_cmp.sv
`timescale 1ns/1ps
// Compares one host address against one relocatable window.
module ldio_win_cmp (
    ldio_win_if.cmp win
);
    logic base_ok;
    logic [11:0] dec_base;
    logic upper_ok;

    // A base outside its permitted range or off its boundary decodes nothing.
    // range guard
    assign base_ok = win.en && (win.base >= win.lo) && (win.base <= win.hi)
        && ((win.base & win.amask) == 12'h000);

    // Only A11..A0 take part in the offset subtraction.
    // low bits
    assign dec_base = win.base + win.add_off;
    assign win.off = win.addr[11:0] - dec_base;

    // With qualification on, A15..A12 must also be zero.
    // upper qualification
    assign upper_ok = !win.qual16 || (win.addr[15:12] == 4'h0);

    assign win.hit = base_ok && upper_ok && (win.off < {4'h0, win.size});
endmodule // ldio_win_cmp

// ### testbench/ldio_host_model.sv
`timescale 1ns/1ps
// Host bus controller that issues one I/O cycle at a time.
module ldio_host_model (
    input wire logic clock,
    input wire logic io_claim,
    input wire logic [7:0] io_rdata_ff,
    output logic io_valid,
    output logic io_write,
    output logic [15:0] io_addr,
    output logic [7:0] io_wdata
);
    logic claim_seen;
    logic [7:0] rdata_seen;

    // Idle bus at time zero.
    initial begin
        io_valid = 1'b0;
        io_write = 1'b0;
        io_addr = 16'hffff;
        io_wdata = 8'hff;
    end

    // single cycle access.
    // The request is held across one rising edge and then dropped.
    // Released lines show the inverse value so a stale read cannot pass.
    task automatic cyc(input logic wr, input logic [15:0] addr, input logic [7:0] data);
        @(negedge clock);
        io_valid = 1'b1;
        io_write = wr;
        io_addr = addr;
        io_wdata = data;
        #1;
        claim_seen = io_claim;
        @(negedge clock);
        io_valid = 1'b0;
        io_addr = ~addr;
        io_wdata = ~data;
        rdata_seen = io_rdata_ff;
    endtask
endmodule // ldio_host_model

// ### testbench/ldio_decoder_monitor.sv
`timescale 1ns/1ps
// Watches the decoder ports for select and offset relations.
module ldio_decoder_monitor #(
    parameter int NUM_WIN = 10
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic io_valid,
    input wire logic io_write,
    input wire logic [15:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_claim,
    input wire logic io_rvalid_ff,
    input wire logic dev_strobe_ff,
    input wire logic dev_write_ff,
    input wire ldio_pkg::ldio_fn_t dev_fn_ff,
    input wire logic [10:0] dev_sel_ff,
    input wire logic [11:0] dev_offset_ff,
    input wire logic [7:0] dev_wdata_ff
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_claim_needs_valid: assert property (!io_valid |-> !io_claim)
        else $error("claim without a request");
    a_strobe_cause: assert property (dev_strobe_ff |-> $past(io_valid && io_claim))
        else $error("strobe without a claimed request");
    a_rvalid_cause: assert property (io_rvalid_ff |-> $past(io_valid && io_claim && !io_write))
        else $error("read answer without a claimed read");
    a_sel_onehot: assert property (dev_strobe_ff |-> $onehot(dev_sel_ff))
        else $error("select not one hot");
    a_sel_idle: assert property (!dev_strobe_ff |-> dev_sel_ff == 11'h000)
        else $error("select outside strobe");
    a_strobe_data: assert property (dev_strobe_ff |->
        dev_write_ff == $past(io_write) && dev_wdata_ff == $past(io_wdata))
        else $error("direction or data not passed");
    a_kbd_ports: assert property (dev_strobe_ff && dev_fn_ff == ldio_pkg::ldio_fn_keyboard_controller_unit
        |-> $past(io_addr[11:0]) == 12'h060 + dev_offset_ff && dev_offset_ff inside {12'h000, 12'h004})
        else $error("keyboard port decode wrong");
    a_ext_span: assert property (dev_strobe_ff && dev_fn_ff == ldio_pkg::ldio_fn_pp_ext
        |-> dev_offset_ff <= 12'h002)
        else $error("extended offset out of span");
    a_ir_span: assert property (dev_strobe_ff && dev_fn_ff == ldio_pkg::ldio_fn_infrared_engine_registers
        |-> dev_offset_ff <= 12'h007 && dev_offset_ff[2:0] == $past(io_addr[2:0]))
        else $error("infrared offset wrong");
    a_game_single: assert property (dev_strobe_ff && dev_fn_ff == ldio_pkg::ldio_fn_game
        |-> dev_offset_ff == 12'h000)
        else $error("game port offset not zero");
endmodule // ldio_decoder_monitor

bind ldio_decoder ldio_decoder_monitor #(.NUM_WIN(NUM_WIN)) i_ldio_decoder_monitor (
    .clock(clock), .rst(rst), .io_valid(io_valid), .io_write(io_write), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_claim(io_claim), .io_rvalid_ff(io_rvalid_ff),
    .dev_strobe_ff(dev_strobe_ff), .dev_write_ff(dev_write_ff), .dev_fn_ff(dev_fn_ff),
    .dev_sel_ff(dev_sel_ff), .dev_offset_ff(dev_offset_ff), .dev_wdata_ff(dev_wdata_ff));

// ### testbench/logical_device_io_decoder_tb.sv
`timescale 1ns/1ps
// Drives host I/O cycles and checks the decoded selects.
module logical_device_io_decoder_tb;
    logic clock, rst, strap, io_valid, io_write, io_claim, io_rvalid_ff;
    logic dev_strobe_ff, dev_write_ff;
    logic [15:0] io_addr, cfg_base;
    logic [7:0] io_wdata, io_rdata_ff, dev_wdata_ff;
    logic [10:0] dev_sel_ff;
    logic [11:0] dev_offset_ff;
    ldio_pkg::ldio_fn_t dev_fn_ff;
    int n_mismatch = 0;
    int comparisons = 0;

    ldio_decoder #(.NUM_WIN(10)) i_ldio_decoder (.clock(clock), .rst(rst),
        .power_up_port_strap(strap), .io_valid(io_valid), .io_write(io_write),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_claim(io_claim),
        .io_rvalid_ff(io_rvalid_ff), .io_rdata_ff(io_rdata_ff), .dev_strobe_ff(dev_strobe_ff),
        .dev_write_ff(dev_write_ff), .dev_fn_ff(dev_fn_ff), .dev_sel_ff(dev_sel_ff),
        .dev_offset_ff(dev_offset_ff), .dev_wdata_ff(dev_wdata_ff));
    ldio_host_model i_ldio_host_model (.clock(clock), .io_claim(io_claim),
        .io_rdata_ff(io_rdata_ff), .io_valid(io_valid), .io_write(io_write),
        .io_addr(io_addr), .io_wdata(io_wdata));

    // Free running clock of 25 ns period.
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic cfgw(input logic [7:0] idx, input logic [7:0] val);
        i_ldio_host_model.cyc(1'b1, cfg_base, idx);
        i_ldio_host_model.cyc(1'b1, cfg_base + 16'h0001, val);
    endtask

    task automatic cfgr(input logic [7:0] idx, input logic [7:0] exp);
        i_ldio_host_model.cyc(1'b1, cfg_base, idx);
        i_ldio_host_model.cyc(1'b0, cfg_base + 16'h0001, 8'h00);
        check({15'h0000, io_rvalid_ff}, 16'h0001);
        check({8'h00, i_ldio_host_model.rdata_seen}, {8'h00, exp});
    endtask

    // A claimed access must raise exactly the expected select and offset.
    task automatic hit(input logic [15:0] a, input ldio_pkg::ldio_fn_t fn, input logic [11:0] off);
        i_ldio_host_model.cyc(1'b0, a, 8'h00);
        check({15'h0000, i_ldio_host_model.claim_seen}, 16'h0001);
        check({15'h0000, dev_strobe_ff}, 16'h0001);
        check({15'h0000, dev_write_ff}, 16'h0000);
        check({12'h000, dev_fn_ff}, {12'h000, fn});
        check({4'h0, dev_offset_ff}, {4'h0, off});
        check({5'h00, dev_sel_ff}, 16'h0001 << fn);
    endtask

    task automatic miss(input logic [15:0] a);
        i_ldio_host_model.cyc(1'b1, a, 8'h5a);
        check({15'h0000, i_ldio_host_model.claim_seen}, 16'h0000);
        check({15'h0000, dev_strobe_ff}, 16'h0000);
    endtask

    // Watchdog against a hung sequence.
    initial begin
        #(25 * 5000);
        n_mismatch++;
        print_verdict();
    end

    // Main sequence of accesses.
    initial begin
        rst = 1'b1;
        strap = 1'b0;
        cfg_base = 16'h002e;
        repeat (8) @(negedge clock);
        rst = 1'b0;
        repeat (5) @(posedge clock);
        check({12'h000, dev_fn_ff}, {12'h000, ldio_pkg::ldio_fn_none});
        cfgw(8'h07, 8'h0a);
        cfgr(8'h07, 8'h0a);
        cfgw(8'h60, 8'h02);
        cfgw(8'h61, 8'h00);
        hit(16'h0200, ldio_pkg::ldio_fn_pme, 12'h000);
        hit(16'h0060, ldio_pkg::ldio_fn_keyboard_controller_unit, 12'h000);
        hit(16'h0064, ldio_pkg::ldio_fn_keyboard_controller_unit, 12'h004);
        i_ldio_host_model.cyc(1'b1, 16'h0064, 8'ha5);
        check({15'h0000, dev_write_ff}, 16'h0001);
        check({8'h00, dev_wdata_ff}, 16'h00a5);
        miss(16'h0062);
        cfgw(8'h07, 8'h03);
        cfgw(8'h60, 8'h03);
        cfgw(8'h61, 8'h78);
        cfgr(8'h60, 8'h03);
        cfgr(8'h61, 8'h78);
        hit(16'h0378, ldio_pkg::ldio_fn_pp, 12'h000);
        hit(16'h037b, ldio_pkg::ldio_fn_pp, 12'h003);
        hit(16'h0778, ldio_pkg::ldio_fn_pp_ext, 12'h000);
        hit(16'h077a, ldio_pkg::ldio_fn_pp_ext, 12'h002);
        miss(16'h077b);
        hit(16'h1378, ldio_pkg::ldio_fn_pp, 12'h000);
        cfgw(8'h24, 8'h40);
        miss(16'h1378);
        hit(16'h037f, ldio_pkg::ldio_fn_pp, 12'h007);
        cfgw(8'h61, 8'h7c);
        miss(16'h037f);
        hit(16'h037e, ldio_pkg::ldio_fn_pp, 12'h002);
        miss(16'h077c);
        cfgw(8'h60, 8'h00);
        cfgw(8'h61, 8'hf8);
        miss(16'h00f8);
        cfgw(8'h07, 8'h09);
        cfgw(8'h60, 8'h01);
        cfgw(8'h61, 8'h01);
        hit(16'h0101, ldio_pkg::ldio_fn_game, 12'h000);
        miss(16'h0102);
        cfgw(8'h07, 8'h05);
        cfgw(8'h62, 8'h02);
        cfgw(8'h63, 8'he8);
        hit(16'h02ef, ldio_pkg::ldio_fn_infrared_engine_registers, 12'h007);
        hit(16'h02e8, ldio_pkg::ldio_fn_infrared_engine_registers, 12'h000);
        cfgw(8'h26, 8'h03);
        cfg_base = 16'h032e;
        cfgw(8'h27, 8'h70);
        cfg_base = 16'h0370;
        cfgr(8'h07, 8'h05);
        i_ldio_host_model.cyc(1'b0, cfg_base, 8'h00);
        check({8'h00, i_ldio_host_model.rdata_seen}, 16'h0007);
        miss(16'h002e);
        // Second reset with the strap high moves the configuration port.
        strap = 1'b1;
        rst = 1'b1;
        repeat (8) @(negedge clock);
        rst = 1'b0;
        repeat (5) @(posedge clock);
        check({12'h000, dev_fn_ff}, {12'h000, ldio_pkg::ldio_fn_none});
        cfg_base = 16'h004e;
        cfgr(8'h27, 8'h4e);
        cfgr(8'h07, 8'h00);
        print_verdict();
    end
endmodule // logical_device_io_decoder_tb
